// ===== hdl/slope_comp_pkg.sv
package slope_comp_pkg;

   // timing of the capacitor discharge one-shot
   localparam int unsigned CLK_PERIOD_NS = 10;
   localparam int unsigned DISCHARGE_NS = 50;
   localparam int unsigned DISCHARGE_CYCLES = (DISCHARGE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // number of ramp restart candidates
   localparam int unsigned NUM_SOURCES = 4;

   // register offsets on the plain register port
   localparam logic [3:0] OFS_CONTROL_MAIN = 4'h0;
   localparam logic [3:0] OFS_RATE_SETTING = 4'h1;
   localparam logic [3:0] OFS_SLOPE_ROUTE = 4'h2;
   localparam logic [3:0] OFS_STATUS = 4'h3;
   localparam logic [3:0] OFS_RESTART_COUNT = 4'h4;

   // field positions of the main control register
   localparam int unsigned ENABLE_BIT = 7;
   localparam int unsigned INVERT_BIT = 4;
   localparam int unsigned TSEL_HI = 3;
   localparam int unsigned TSEL_LO = 2;
   localparam int unsigned REFSEL_BIT = 0;

   // field positions of the rate setting register
   localparam int unsigned RANGE_BIT = 4;
   localparam int unsigned ISET_HI = 3;
   localparam int unsigned ISET_LO = 0;

   // field positions of the route and status registers
   localparam int unsigned ROUTE_CMP_ONE_BIT = 0;
   localparam int unsigned ROUTE_CMP_TWO_BIT = 1;
   localparam int unsigned ROUTE_OPAMP_BIT = 2;
   localparam int unsigned STAT_BUSY_BIT = 0;
   localparam int unsigned STAT_TRIG_BIT = 1;
   localparam int unsigned STAT_ENABLE_BIT = 2;

   // values after reset
   localparam logic [3:0] ISET_RESET = 4'h0;
   localparam logic [2:0] ROUTE_RESET = 3'h0;
   localparam logic [7:0] COUNT_RESET = 8'h00;

   // slope in hundredths of a volt per microsecond
   localparam logic [7:0] SLOPE_LOW_BASE = 8'h14;
   localparam logic [7:0] SLOPE_LOW_STEP = 8'h05;
   localparam logic [7:0] SLOPE_HIGH_BASE = 8'h64;
   localparam logic [7:0] SLOPE_HIGH_STEP = 8'h0a;

   // sink current in half microamps
   localparam logic [5:0] SINK_LOW_BASE = 6'h04;
   localparam logic [5:0] SINK_LOW_STEP = 6'h01;
   localparam logic [5:0] SINK_HIGH_BASE = 6'h14;
   localparam logic [5:0] SINK_HIGH_STEP = 6'h02;

   // restart source encoding
   typedef enum logic [1:0] {
      SRC_COMP_OUT_A = 2'h0,
      SRC_COMP_OUT_B = 2'h1,
      SRC_CMP_ONE = 2'h2,
      SRC_CMP_TWO = 2'h3
   } trig_src_t;

endpackage

// ===== hdl/trig_if.sv
`timescale 1ns/1ps
interface trig_if
   import slope_comp_pkg::*;
   ;
   logic [NUM_SOURCES-1:0] level;
   logic fire;
   logic busy;
   modport sync_mp (output level);
   modport ctl_mp (input level, output fire, input busy);
   modport pulse_mp (input fire, output busy);
endinterface

// ===== hdl/trigger_sync.sv
`timescale 1ns/1ps
module trigger_sync
   import slope_comp_pkg::*;
(
   input wire logic ref_clk_i,
   input wire logic rstn_i,
   input wire logic [NUM_SOURCES-1:0] async_i,
   trig_if.sync_mp tif
);

   logic [NUM_SOURCES-1:0] s1_q;
   logic [NUM_SOURCES-1:0] s2_q;
   logic [NUM_SOURCES-1:0] s3_q;
   logic [NUM_SOURCES-1:0] level_q;

   // three stages per source; a new level is accepted only when stages two and three agree
   for (genvar i = 0; i < NUM_SOURCES; i++)
   begin : g_src
      always_ff @(posedge ref_clk_i or negedge rstn_i)
      begin
         if (!rstn_i)
         begin
            s1_q[i] <= 1'b0;
            s2_q[i] <= 1'b0;
            s3_q[i] <= 1'b0;
            level_q[i] <= 1'b0;
         end
         else
         begin
            s1_q[i] <= async_i[i];
            s2_q[i] <= s1_q[i];
            s3_q[i] <= s2_q[i];
            if (s2_q[i] == s3_q[i]) level_q[i] <= s3_q[i]; // R16
         end
      end
   end

   assign tif.level = level_q;

   chk_sync_agree: // R16
   assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
      ((level_q ^ $past(level_q)) & ~($past(s2_q) ~^ $past(s3_q))) == '0)
   else $error("synchronised level moved while stages disagreed");

endmodule

// ===== hdl/discharge_pulse.sv
`timescale 1ns/1ps
module discharge_pulse
   import slope_comp_pkg::*;
#(
   parameter int unsigned PULSE_CYCLES = DISCHARGE_CYCLES
)
(
   input wire logic ref_clk_i,
   input wire logic rstn_i,
   trig_if.pulse_mp tif
);

   logic [7:0] cnt_q;

   // a new trigger reloads the count, so a retrigger stretches the pulse rather than cutting it
   always_ff @(posedge ref_clk_i or negedge rstn_i)
   begin
      if (!rstn_i) cnt_q <= 8'h00;
      else if (tif.fire) cnt_q <= PULSE_CYCLES[7:0]; // R15
      else if (cnt_q != 8'h00) cnt_q <= cnt_q - 8'h01;
   end

   assign tif.busy = (cnt_q != 8'h00);

   chk_pulse_len: // R15
   assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
      tif.fire |=> tif.busy [*5])
   else $error("discharge pulse shorter than five cycles");

   // a retrigger reloads the count, so the end is only checked after five quiet cycles
   chk_pulse_end: // R15
   assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
      tif.fire ##1 (!tif.fire) [*5] |=> !tif.busy)
   else $error("discharge pulse longer than five cycles");

endmodule

// ===== hdl/slope_comp_control.sv
`timescale 1ns/1ps
// Summary of operation
// R1 - main control: enable bit7, invert bit4, source select bits3-2, reference select bit0.
// R2 - rate setting: range bit4, four-bit sink code bits3-0, upper bits absent.
// R3 - upper three bits of the rate setting read zero and ignore writes.
// R4 - any reset disables the ramp and clears every control field.
// R5 - sleep changes nothing; the block keeps running exactly as when awake.
// R6 - restart source is one of two complementary outputs or two comparators.
// R7 - the compensated slope can go to either comparator and the op amp.
// R8 - range bit and four-bit code form the five-bit sink code sent out.
// R9 - low range slope is code times 0.75/15 plus 0.2 V/us.
// R10 - high range slope is 1.0 V/us plus 0.1 V/us per code step.
// R11 - sink current 2 uA + 0.5 uA/step low, 10 uA + 1 uA/step high.
// R12 - the invert bit flips the selected source before it restarts the ramp.
// R13 - reference select picks buffered fixed reference when set, input pin when clear.
// R14 - each active trigger discharges the ramp capacitor to restart the slope.
// R15 - each trigger fires a one-shot discharge of about 50 ns.
// R16 - source is synchronised; discharge starts on its rising edge only while enabled.
// R17 - writes act on the following edge; reads return current field values.
module slope_comp_control
   import slope_comp_pkg::*;
#(
   parameter int unsigned PULSE_CYCLES = DISCHARGE_CYCLES
)
(
   input wire logic ref_clk_i,
   input wire logic rstn_i,
   input wire logic [3:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [7:0] rdata_o,
   input wire logic complementary_out_a_i,
   input wire logic complementary_out_b_i,
   input wire logic comparator_one_i,
   input wire logic comparator_two_i,
   output logic discharge_o,
   output logic ramp_enable_o,
   output logic reference_input_select_o,
   output logic [4:0] sink_current_code_o,
   output logic slope_to_comparator_one_o,
   output logic slope_to_comparator_two_o,
   output logic slope_to_opamp_o,
   output logic [7:0] slope_centi_o,
   output logic [5:0] sink_current_halfua_o
);

   trig_if tif ();

   // control fields
   logic ramp_enable_q;
   logic trigger_invert_q;
   trig_src_t trigger_source_select_q;
   logic reference_input_select_q;
   logic slope_range_select_q;
   logic [3:0] sink_current_code_q;
   logic [2:0] route_q;

   // status and derived values
   logic [7:0] restart_count_q;
   logic [7:0] rdata_q;
   logic [7:0] slope_centi_q;
   logic [5:0] sink_halfua_q;
   logic trig_prev_q;
   logic selected_level;
   logic trig_now;
   logic [7:0] read_mux;

   logic wr_main;
   logic wr_rate;
   logic wr_route;

   assign wr_main = wr_i && (addr_i == OFS_CONTROL_MAIN);
   assign wr_rate = wr_i && (addr_i == OFS_RATE_SETTING);
   assign wr_route = wr_i && (addr_i == OFS_SLOPE_ROUTE);

   // all four restart candidates come from other blocks or pins, so they all get synchronised
   trigger_sync u_sync (
      .ref_clk_i(ref_clk_i),
      .rstn_i(rstn_i),
      .async_i({comparator_two_i, comparator_one_i, complementary_out_b_i, complementary_out_a_i}),
      .tif(tif.sync_mp)
   );

   discharge_pulse #(
      .PULSE_CYCLES(PULSE_CYCLES)
   ) u_pulse (
      .ref_clk_i(ref_clk_i),
      .rstn_i(rstn_i),
      .tif(tif.pulse_mp)
   );

   // main control register; there is no sleep input at all, so nothing can freeze it
   always_ff @(posedge ref_clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         ramp_enable_q <= 1'b0; // R4
         trigger_invert_q <= 1'b0;
         trigger_source_select_q <= SRC_COMP_OUT_A;
         reference_input_select_q <= 1'b0;
      end
      else if (wr_main)
      begin
         ramp_enable_q <= wdata_i[ENABLE_BIT]; // R1 R17 R5
         trigger_invert_q <= wdata_i[INVERT_BIT];
         trigger_source_select_q <= trig_src_t'(wdata_i[TSEL_HI:TSEL_LO]);
         reference_input_select_q <= wdata_i[REFSEL_BIT];
      end
   end

   // rate setting; bits 7-5 are simply never stored
   always_ff @(posedge ref_clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         slope_range_select_q <= 1'b0; // R4
         sink_current_code_q <= ISET_RESET;
      end
      else if (wr_rate)
      begin
         slope_range_select_q <= wdata_i[RANGE_BIT]; // R2 R3
         sink_current_code_q <= wdata_i[ISET_HI:ISET_LO];
      end
   end

   // slope routing toward the comparators and op amp
   always_ff @(posedge ref_clk_i or negedge rstn_i)
   begin
      if (!rstn_i) route_q <= ROUTE_RESET;
      else if (wr_route) route_q <= wdata_i[2:0]; // R7
   end

   // pick the restart source, then apply polarity
   always_comb
   begin
      unique case (trigger_source_select_q) // R6
         SRC_COMP_OUT_A: selected_level = tif.level[0];
         SRC_COMP_OUT_B: selected_level = tif.level[1];
         SRC_CMP_ONE: selected_level = tif.level[2];
         SRC_CMP_TWO: selected_level = tif.level[3];
      endcase
   end

   assign trig_now = selected_level ^ trigger_invert_q; // R12

   // edge history always tracks, so enabling on a high level does not fire at once
   always_ff @(posedge ref_clk_i or negedge rstn_i)
   begin
      if (!rstn_i) trig_prev_q <= 1'b0;
      else trig_prev_q <= trig_now;
   end

   // a source or polarity change can look like an edge; software should change them while disabled
   assign tif.fire = ramp_enable_q && trig_now && !trig_prev_q; // R16 R14

   // count ramp restarts so software can see the loop is running
   always_ff @(posedge ref_clk_i or negedge rstn_i)
   begin
      if (!rstn_i) restart_count_q <= COUNT_RESET;
      else if (tif.fire) restart_count_q <= restart_count_q + 8'h01;
   end

   // slope and sink current figures for the analog trim, registered so outputs come from flops
   always_ff @(posedge ref_clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         slope_centi_q <= SLOPE_LOW_BASE;
         sink_halfua_q <= SINK_LOW_BASE;
      end
      else if (slope_range_select_q)
      begin
         slope_centi_q <= SLOPE_HIGH_BASE + 8'(SLOPE_HIGH_STEP * {4'h0, sink_current_code_q}); // R10
         sink_halfua_q <= SINK_HIGH_BASE + 6'(SINK_HIGH_STEP * {2'h0, sink_current_code_q}); // R11
      end
      else
      begin
         slope_centi_q <= SLOPE_LOW_BASE + 8'(SLOPE_LOW_STEP * {4'h0, sink_current_code_q}); // R9
         sink_halfua_q <= SINK_LOW_BASE + 6'(SINK_LOW_STEP * {2'h0, sink_current_code_q}); // R11
      end
   end

   // read decode; unmapped offsets read zero
   always_comb
   begin
      read_mux = 8'h00;
      unique case (addr_i)
         OFS_CONTROL_MAIN:
         begin
            read_mux[ENABLE_BIT] = ramp_enable_q; // R1
            read_mux[INVERT_BIT] = trigger_invert_q;
            read_mux[TSEL_HI:TSEL_LO] = trigger_source_select_q;
            read_mux[REFSEL_BIT] = reference_input_select_q;
         end
         OFS_RATE_SETTING:
         begin
            read_mux[RANGE_BIT] = slope_range_select_q; // R2 R3
            read_mux[ISET_HI:ISET_LO] = sink_current_code_q;
         end
         OFS_SLOPE_ROUTE: read_mux[2:0] = route_q;
         OFS_STATUS:
         begin
            read_mux[STAT_BUSY_BIT] = tif.busy;
            read_mux[STAT_TRIG_BIT] = trig_now;
            read_mux[STAT_ENABLE_BIT] = ramp_enable_q;
         end
         OFS_RESTART_COUNT: read_mux = restart_count_q;
         default: read_mux = 8'h00;
      endcase
   end

   // read data stands only in the cycle after the strobe
   always_ff @(posedge ref_clk_i or negedge rstn_i)
   begin
      if (!rstn_i) rdata_q <= 8'h00;
      else if (rd_i) rdata_q <= read_mux; // R17
      else rdata_q <= 8'h00;
   end

   // outputs toward the register port and the analog section
   assign rdata_o = rdata_q;
   assign discharge_o = tif.busy; // R14
   assign ramp_enable_o = ramp_enable_q;
   assign reference_input_select_o = reference_input_select_q; // R13
   assign sink_current_code_o = {slope_range_select_q, sink_current_code_q}; // R8
   assign slope_to_comparator_one_o = route_q[ROUTE_CMP_ONE_BIT];
   assign slope_to_comparator_two_o = route_q[ROUTE_CMP_TWO_BIT];
   assign slope_to_opamp_o = route_q[ROUTE_OPAMP_BIT];
   assign slope_centi_o = slope_centi_q;
   assign sink_current_halfua_o = sink_halfua_q;

   chk_main_layout: // R1
   assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
      wr_main ##1 (rd_i && addr_i == OFS_CONTROL_MAIN) |=>
         rdata_o == ($past(wdata_i, 2) & 8'h9d))
   else $error("main control readback does not match written fields");

   chk_rate_upper: // R3
   assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
      (rd_i && addr_i == OFS_RATE_SETTING) |=> rdata_o[7:5] == 3'h0)
   else $error("rate setting upper bits read nonzero");

   chk_reset_clear: // R4
   assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
      $rose(rstn_i) |-> (!ramp_enable_o && !discharge_o && sink_current_code_o == 5'h00
         && !reference_input_select_o && route_q == 3'h0))
   else $error("control not cleared after reset");

   chk_write_effect: // R17
   assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
      wr_rate |=> sink_current_code_o == $past(wdata_i[4:0]))
   else $error("rate write did not take effect on the next edge");

   chk_ref_select: // R13
   assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
      wr_main |=> reference_input_select_o == $past(wdata_i[0]))
   else $error("reference select does not follow bit zero");

   chk_route_write: // R7
   assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
      wr_route |=> {slope_to_opamp_o, slope_to_comparator_two_o, slope_to_comparator_one_o} == $past(wdata_i[2:0]))
   else $error("slope routing does not follow the write");

   chk_low_slope: // R9
   assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
      (sink_current_code_o == 5'h06) |=> slope_centi_o == 8'h32)
   else $error("low range code 6 is not 0.50 V/us");

   chk_high_slope: // R10
   assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
      (sink_current_code_o == 5'h1f) |=> slope_centi_o == 8'hfa)
   else $error("high range top code is not 2.50 V/us");

   chk_sink_current: // R11
   assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
      (sink_current_code_o == 5'h10) |=> sink_current_halfua_o == 6'h14)
   else $error("code 10h is not 10 uA");

   chk_fire_enabled: // R16
   assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
      tif.fire |-> ramp_enable_o && !$past(trig_now))
   else $error("discharge fired while disabled or without an edge");

   chk_polarity: // R12
   assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
      (tif.fire && $stable(trigger_source_select_q) && $stable(trigger_invert_q))
         |-> $past(tif.level[trigger_source_select_q]) == trigger_invert_q)
   else $error("fired on the wrong trigger polarity");

   chk_restart_discharge: // R14
   assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
      tif.fire |=> discharge_o ##0 restart_count_q == $past(restart_count_q) + 8'h01)
   else $error("trigger did not start discharge and count");

   // readback checks watch rdata_o itself, so a wrong decode or a stale strobe shows up here
   chk_main_reserved: // R1
   assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
      (rd_i && addr_i == OFS_CONTROL_MAIN) |=> (rdata_o & 8'h62) == 8'h00)
   else $error("main control reserved bits read nonzero");

   chk_rdata_idle: // R17
   assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
      !rd_i |=> rdata_o == 8'h00)
   else $error("read data present without a read strobe");

   chk_unmapped_zero: // R17
   assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
      (rd_i && addr_i > OFS_RESTART_COUNT) |=> rdata_o == 8'h00)
   else $error("unmapped offset read nonzero");

   chk_status_bits: // R16
   assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
      (rd_i && addr_i == OFS_STATUS) |=> rdata_o[7:3] == 5'h00
         && rdata_o[STAT_ENABLE_BIT] == $past(ramp_enable_o) && rdata_o[STAT_BUSY_BIT] == $past(discharge_o))
   else $error("status readback does not match enable and discharge");

   // hold checks: settings and the count move only when something asks them to
   chk_count_hold: // R14
   assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
      !tif.fire |=> restart_count_q == $past(restart_count_q))
   else $error("restart count moved without a trigger");

   chk_code_hold: // R17
   assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
      !wr_rate |=> $stable(sink_current_code_o))
   else $error("sink code changed without a rate write");

   chk_route_hold: // R7
   assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
      !wr_route |=> $stable({slope_to_opamp_o, slope_to_comparator_two_o, slope_to_comparator_one_o}))
   else $error("slope routing changed without a route write");

   chk_idle_quiet: // R16
   assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
      (!ramp_enable_o && !discharge_o) |=> !discharge_o)
   else $error("discharge started while disabled");

   // end points of both ranges, worked from the base and step of each
   chk_low_base: // R9
   assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
      (sink_current_code_o == 5'h00) |=> slope_centi_o == 8'h14 && sink_current_halfua_o == 6'h04)
   else $error("code 0 is not 0.20 V/us and 2 uA");

   chk_high_base: // R10
   assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
      (sink_current_code_o == 5'h10) |=> slope_centi_o == 8'h64)
   else $error("code 10h is not 1.00 V/us");

   chk_sink_low: // R11
   assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
      (sink_current_code_o == 5'h0f) |=> sink_current_halfua_o == 6'h13)
   else $error("code 0fh is not 9.5 uA");

endmodule

// ===== test/slope_far_model.sv
`timescale 1ns/1ps
// stand-in for the comparators and the complementary outputs that restart the ramp
module slope_far_model
   import slope_comp_pkg::*;
(
   input wire logic ref_clk_i,
   input wire logic rstn_i,
   input wire logic go_i,
   input wire logic [1:0] pick_i,
   input wire logic idle_i,
   output logic [NUM_SOURCES-1:0] src_o
);
   logic [1:0] left_q;
   logic [1:0] pick_q;

   // one candidate leaves its idle level for three cycles, enough for the sync stage
   always_ff @(posedge ref_clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         left_q <= 2'h0;
         pick_q <= 2'h0;
      end
      else if (go_i)
      begin
         left_q <= 2'h3;
         pick_q <= pick_i;
      end
      else if (left_q != 2'h0)
      begin
         left_q <= left_q - 2'h1;
      end
   end

   // the other three lines hold the idle level, as a quiet converter would
   always_comb
   begin
      src_o = {NUM_SOURCES{idle_i}};
      if (left_q != 2'h0)
      begin
         src_o[pick_q] = ~idle_i;
      end
   end
endmodule

// ===== test/slope_comp_control_tb.sv
`timescale 1ns/1ps
`define CHK(got, want) begin checked++; if ((got) !== (want)) begin failures++; \
   $display("CHECK FAILED t=%0t got %h want %h", $time, got, want); end end
module slope_comp_control_tb;
   import slope_comp_pkg::*;
   typedef struct {logic [3:0] a; logic [7:0] d; logic [7:0] r; logic [4:0] o;} row_t;
   localparam int PC = 5;
   logic ref_clk_i = 1'b0;
   logic rstn_i = 1'b0;
   logic [3:0] addr_i = 4'h0;
   logic [7:0] wdata_i = 8'h00;
   logic wr_i = 1'b0;
   logic rd_i = 1'b0;
   logic [7:0] rdata_o;
   logic discharge_o, ramp_enable_o, reference_input_select_o;
   logic [4:0] sink_current_code_o;
   logic s_one, s_two, s_op;
   logic [7:0] slope_centi_o;
   logic [5:0] sink_current_halfua_o;
   logic go = 1'b0;
   logic idle = 1'b0;
   logic [1:0] pick = 2'h0;
   logic [3:0] src;
   logic [7:0] rv;
   int failures = 0;
   int checked = 0;
   row_t rows [9] = '{
      '{4'h0, 8'hef, 8'h8d, 5'h18}, '{4'h1, 8'hff, 8'h1f, 5'h18}, '{4'h2, 8'hff, 8'h07, 5'h1f},
      '{4'h2, 8'h05, 8'h05, 5'h1d}, '{4'h0, 8'h62, 8'h00, 5'h05}, '{4'h7, 8'hff, 8'h00, 5'h05},
      '{4'h3, 8'hff, 8'h00, 5'h05}, '{4'h1, 8'he0, 8'h00, 5'h05}, '{4'h4, 8'hff, 8'h00, 5'h05}};

   slope_comp_control #(.PULSE_CYCLES(PC)) dut_u (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i),
      .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
      .complementary_out_a_i(src[0]), .complementary_out_b_i(src[1]), .comparator_one_i(src[2]),
      .comparator_two_i(src[3]), .discharge_o(discharge_o), .ramp_enable_o(ramp_enable_o),
      .reference_input_select_o(reference_input_select_o), .sink_current_code_o(sink_current_code_o),
      .slope_to_comparator_one_o(s_one), .slope_to_comparator_two_o(s_two), .slope_to_opamp_o(s_op),
      .slope_centi_o(slope_centi_o), .sink_current_halfua_o(sink_current_halfua_o));

   slope_far_model far_u (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .go_i(go), .pick_i(pick),
      .idle_i(idle), .src_o(src));

   // free-running system clock
   initial
   begin
      forever #5 ref_clk_i = ~ref_clk_i;
   end

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge ref_clk_i);
      wr_i <= 1'b1;
      addr_i <= a;
      wdata_i <= d;
      @(posedge ref_clk_i);
      wr_i <= 1'b0;
   endtask

   // read data stand only in the cycle after the strobe, so they are taken right there
   task automatic rd(input logic [3:0] a);
      @(posedge ref_clk_i);
      rd_i <= 1'b1;
      addr_i <= a;
      @(posedge ref_clk_i);
      rd_i <= 1'b0;
      #1 rv = rdata_o;
   endtask

   // write, then read back with no gap, so the readback meets the write on its first edge
   task automatic wr_rd(input logic [3:0] a, input logic [7:0] d);
      wr(a, d);
      rd_i <= 1'b1;
      @(posedge ref_clk_i);
      rd_i <= 1'b0;
      #1 rv = rdata_o;
   endtask

   // bounded wait for a discharge, then its width in cycles
   task automatic fire_and_see(input logic [1:0] s, input logic want);
      int n;
      int w;
      n = 0;
      w = 0;
      @(posedge ref_clk_i);
      go <= 1'b1;
      pick <= s;
      @(posedge ref_clk_i);
      go <= 1'b0;
      #1;
      while (discharge_o !== 1'b1 && n < 12)
      begin
         @(posedge ref_clk_i);
         #1 n++;
      end
      `CHK(discharge_o, want)
      while (discharge_o === 1'b1 && w < 20)
      begin
         @(posedge ref_clk_i);
         #1 w++;
      end
      if (want)
         `CHK(w, PC)
   endtask

   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", checked, failures);
      if (failures == 0 && checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // cut a hang short well past the few hundred cycles the run needs
   initial
   begin
      #200000;
      failures++;
      stop_test();
   end

   initial
   begin
      repeat (3) @(posedge ref_clk_i);
      rstn_i <= 1'b1;
      #1 `CHK(slope_centi_o, 8'h14)
      // register map rows: write, then read back and look at the control outputs
      foreach (rows[i])
      begin
         wr_rd(rows[i].a, rows[i].d);
         `CHK(rv, rows[i].r)
         `CHK({ramp_enable_o, reference_input_select_o, s_op, s_two, s_one}, rows[i].o)
         @(posedge ref_clk_i);
         #1 `CHK(rdata_o, 8'h00)
      end
      // every range and sink code, figures worked from the slope and current steps
      for (int c = 0; c < 32; c++)
      begin
         wr(OFS_RATE_SETTING, 8'(c) | 8'he0);
         @(posedge ref_clk_i);
         #1 `CHK(sink_current_code_o, 5'(c))
         `CHK(slope_centi_o, 8'((c < 16) ? 20 + 5 * c : 100 + 10 * (c - 16)))
         `CHK(sink_current_halfua_o, 6'((c < 16) ? 4 + c : 20 + 2 * (c - 16)))
         rd(OFS_RATE_SETTING);
         `CHK(rv, 8'(c))
      end
      // each restart source while enabled, then one while disabled
      for (int s = 0; s < 4; s++)
      begin
         wr(OFS_CONTROL_MAIN, 8'h80 | 8'(s << 2));
         fire_and_see(2'(s), 1'b1);
      end
      wr(OFS_CONTROL_MAIN, 8'h00);
      fire_and_see(2'h1, 1'b0);
      // inverted polarity: the lines idle high and a low-going pulse restarts the ramp
      @(posedge ref_clk_i);
      idle <= 1'b1;
      repeat (6) @(posedge ref_clk_i);
      wr(OFS_CONTROL_MAIN, 8'h9c);
      repeat (6) @(posedge ref_clk_i);
      rd(OFS_STATUS);
      `CHK(rv, 8'h04)
      fire_and_see(2'h3, 1'b1);
      rd(OFS_RESTART_COUNT);
      `CHK(rv, 8'h05)
      // reset in mid-run clears every control field
      wr(OFS_CONTROL_MAIN, 8'h81);
      @(posedge ref_clk_i);
      rstn_i <= 1'b0;
      repeat (3) @(posedge ref_clk_i);
      #1 `CHK({ramp_enable_o, reference_input_select_o, sink_current_code_o}, 7'h00)
      `CHK(slope_centi_o, 8'h14)
      @(posedge ref_clk_i);
      rstn_i <= 1'b1;
      rd(OFS_CONTROL_MAIN);
      `CHK(rv, 8'h00)
      rd(OFS_RATE_SETTING);
      `CHK(rv, 8'h00)
      stop_test();
   end
endmodule
